// >>> src/tqa_consts.vh
// Register offsets, field positions, reset values and timing counts for the transmit queue control.
`ifndef TQA_CONSTS_VH
`define TQA_CONSTS_VH
`define TQA_ADDR_W          18
`define TQA_OFF_TAIL0       18'h03818
`define TQA_OFF_TAIL1       18'h03918
`define TQA_OFF_DELAY       18'h03820
`define TQA_OFF_ABS         18'h0382c
`define TQA_OFF_ARB0        18'h03840
`define TQA_OFF_ARB1        18'h03940
`define TQA_OFF_HEAD0       18'h03810
`define TQA_OFF_HEAD1       18'h03910
`define TQA_OFF_STATUS      18'h038f0
`define TQA_CNT_LSB         0
`define TQA_CNT_MSB         6
`define TQA_COMP_BIT        7
`define TQA_RATIO_LSB       8
`define TQA_RATIO_MSB       9
`define TQA_EN_BIT          10
`define TQA_FLUSH_BIT       31
`define TQA_CNT_RESET       7'h03
`define TQA_EN_RESET        1'h1
`define TQA_TICK_PS         1024000
`define TQA_CLK_PS          25000
`define TQA_TICK_CYCLES     (`TQA_TICK_PS / `TQA_CLK_PS)
`endif

// >>> src/tqa_timer.v
// Reloadable countdown in prescaler ticks (1.000 us by default) used for delayed and absolute interrupt timing.
`timescale 1ns/100ps
`default_nettype none
module tqa_timer #(
   parameter W = 16
) (
   input  wire         clk_in,
   input  wire         srst_in,
   input  wire         ce_in,
   input  wire         tick_in,
   input  wire         start_in,
   input  wire         halt_in,
   input  wire [W-1:0] reload_in,
   output reg          expire_out,
   output reg          run_out
);
   reg [W-1:0] count;

   // Start reloads and runs unless the reload is zero; halt reloads and stops; expiry is a one-cycle pulse.
   always @(posedge clk_in) begin
      if (srst_in) begin
         count      <= {W{1'b0}};
         run_out    <= 1'b0;
         expire_out <= 1'b0;
      end else if (ce_in) begin
         expire_out <= 1'b0;
         if (halt_in) begin
            count   <= reload_in;
            run_out <= 1'b0;
         end else if (start_in) begin
            count   <= reload_in;
            run_out <= (reload_in != {W{1'b0}});
         end else if (run_out && tick_in) begin
            if (count <= {{(W-1){1'b0}}, 1'b1}) begin
               run_out    <= 1'b0;
               expire_out <= 1'b1;
               count      <= reload_in;
            end else begin
               count <= count - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/tqa_core.v
// Two-queue transmit tail pointers, weighted arbitration and interrupt delay timers.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "tqa_consts.vh"
module tqa_core #(
   parameter IDX_W    = 16,
   parameter CNT_W    = 7,
   parameter TICK_CYC = `TQA_TICK_CYCLES
) (
   input  wire                   clk_in,
   input  wire                   srst_in,
   input  wire                   ce_in,
   input  wire [`TQA_ADDR_W-1:0] addr_in,
   input  wire [31:0]            wdata_in,
   input  wire                   wr_in,
   input  wire                   rd_in,
   output reg  [31:0]            rdata_out,
   input  wire                   tx_enable_in,
   input  wire                   mac_ready_in,
   input  wire                   done_in,
   input  wire                   done_queue_in,
   input  wire [7:0]             done_pkts_in,
   input  wire                   done_report_status_flag_in,
   input  wire                   done_delay_enable_flag_in,
   output reg                    send_valid_out,
   output reg                    send_queue_out,
   output reg  [IDX_W-1:0]       send_index_out,
   output reg                    writeback_out,
   output reg                    tx_complete_cause_out
);
   reg [IDX_W-1:0] tail0, tail1, head0, head1;
   reg [CNT_W:0]   cnt0, cnt1;       // Signed live counters, one spare bit.
   reg [CNT_W-1:0] high0, high1;
   reg             comp0, comp1, en0, en1;
   reg [1:0]       ratio0, ratio1;
   reg [15:0]      delay_reload_value, abs_reload;
   reg             cur_q, busy;
   reg [15:0]      tick_cnt;
   reg             tick;
   reg             flush_partial_block;
   wire            dly_exp, dly_run, abs_exp, abs_run;

   wire wr_delay = wr_in && (addr_in == `TQA_OFF_DELAY);
   wire flush_req = wr_delay && wdata_in[`TQA_FLUSH_BIT];

   // Queue zero is always considered enabled; the enable of queue one gates it.
   wire ne0 = (head0 != tail0) && tx_enable_in;
   wire ne1 = (head1 != tail1) && tx_enable_in && en1;

   // Completion classes for delay timing.
   wire q_delay = done_in && done_report_status_flag_in && done_delay_enable_flag_in;
   wire q_imm   = done_in && done_report_status_flag_in && !done_delay_enable_flag_in;
   wire abs_go  = q_delay && !abs_run;

   // Free-running tick prescaler: one tick every TICK_CYC cycles, 40 cycles of 25 ns (1.000 us) by default.
   always @(posedge clk_in) begin
      if (srst_in) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (ce_in) begin
         tick <= 1'b0;
         if (tick_cnt == TICK_CYC[15:0] - 16'h0001) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
      end
   end

   tqa_timer #(.W(16)) u_delay (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .ce_in      (ce_in),
      .tick_in    (tick),
      .start_in   (q_delay),
      .halt_in    (q_imm || abs_exp || flush_req),
      .reload_in  (delay_reload_value),
      .expire_out (dly_exp),
      .run_out    (dly_run)
   );

   tqa_timer #(.W(16)) u_abs (
      .clk_in     (clk_in),
      .srst_in    (srst_in),
      .ce_in      (ce_in),
      .tick_in    (tick),
      .start_in   (abs_go),
      .halt_in    (q_imm || dly_exp || flush_req),
      .reload_in  (abs_reload),
      .expire_out (abs_exp),
      .run_out    (abs_run)
   );

   // Compensation amount: deficit shifted by the receiving queue's ratio, truncated.
   function [CNT_W:0] comp_amt;
      input [CNT_W:0] deficit;
      input [1:0]     ratio;
      begin
         comp_amt = deficit >> ratio;
      end
   endfunction

   // Saturating signed subtract; result never wraps past the most negative value.
   function [CNT_W:0] sub_sat;
      input [CNT_W:0] a;
      input [7:0]     n;
      reg   [9:0]     d;
      begin
         d = {{2{a[CNT_W]}}, a} - {2'b00, n};
         if (d[9] && (d[9:CNT_W] != {(10-CNT_W){1'b1}}))
            sub_sat = {1'b1, {CNT_W{1'b0}}};
         else
            sub_sat = d[CNT_W:0];
      end
   endfunction

   // Saturating positive add used for compensation.
   function [CNT_W:0] add_sat;
      input [CNT_W:0] a;
      input [CNT_W:0] b;
      reg   [CNT_W+1:0] s;
      begin
         s = {a[CNT_W], a} + {1'b0, b};
         if (!a[CNT_W] && s[CNT_W])
            add_sat = {1'b0, {CNT_W{1'b1}}};
         else
            add_sat = s[CNT_W:0];
      end
   endfunction

   reg [CNT_W:0] nc_done, nc_oth;
   reg           dropped;

   // Counter update for the queue that just finished, and compensation of the other.
   always @* begin
      nc_done = sub_sat(done_queue_in ? cnt1 : cnt0, done_pkts_in);
      nc_oth  = done_queue_in ? cnt0 : cnt1;
      dropped = nc_done[CNT_W];
      if (dropped && comp0 && comp1) begin
         if (done_queue_in)
            nc_oth = add_sat(cnt0, comp_amt(-nc_done, ratio0));
         else
            nc_oth = add_sat(cnt1, comp_amt(-nc_done, ratio1));
      end
      if (dropped)
         nc_done = {1'b0, done_queue_in ? high1 : high0};
   end

   // Register writes, head advance, arbitration and counters.
   always @(posedge clk_in) begin
      if (srst_in) begin
         tail0 <= {IDX_W{1'b0}};
         tail1 <= {IDX_W{1'b0}};
         head0 <= {IDX_W{1'b0}};
         head1 <= {IDX_W{1'b0}};
         cnt0  <= {1'b0, `TQA_CNT_RESET};
         cnt1  <= {1'b0, `TQA_CNT_RESET};
         high0 <= `TQA_CNT_RESET;
         high1 <= `TQA_CNT_RESET;
         comp0 <= 1'b0;
         comp1 <= 1'b0;
         ratio0 <= 2'b00;
         ratio1 <= 2'b00;
         en0   <= `TQA_EN_RESET;
         en1   <= `TQA_EN_RESET;
         delay_reload_value <= 16'h0000;
         abs_reload <= 16'h0000;
         cur_q <= 1'b0;
         busy  <= 1'b0;
         send_valid_out <= 1'b0;
         send_queue_out <= 1'b0;
         send_index_out <= {IDX_W{1'b0}};
      end else if (ce_in) begin
         send_valid_out <= 1'b0;
         if (wr_in) begin
            case (addr_in)
               `TQA_OFF_TAIL0: tail0 <= wdata_in[IDX_W-1:0];
               `TQA_OFF_TAIL1: tail1 <= wdata_in[IDX_W-1:0];
               `TQA_OFF_HEAD0: if (!tx_enable_in) head0 <= wdata_in[IDX_W-1:0];
               `TQA_OFF_HEAD1: if (!tx_enable_in) head1 <= wdata_in[IDX_W-1:0];
               `TQA_OFF_ARB0: begin
                  high0  <= wdata_in[`TQA_CNT_MSB:`TQA_CNT_LSB];
                  comp0  <= wdata_in[`TQA_COMP_BIT];
                  ratio0 <= wdata_in[`TQA_RATIO_MSB:`TQA_RATIO_LSB];
                  en0    <= wdata_in[`TQA_EN_BIT];
               end
               `TQA_OFF_ARB1: begin
                  high1  <= wdata_in[`TQA_CNT_MSB:`TQA_CNT_LSB];
                  comp1  <= wdata_in[`TQA_COMP_BIT];
                  ratio1 <= wdata_in[`TQA_RATIO_MSB:`TQA_RATIO_LSB];
                  en1    <= wdata_in[`TQA_EN_BIT];
               end
               `TQA_OFF_DELAY: delay_reload_value <= wdata_in[15:0];
               `TQA_OFF_ABS:   abs_reload <= wdata_in[15:0];
               default: ;
            endcase
         end
         // Completion of the packet in flight updates counters and may switch queues.
         if (done_in && busy) begin
            busy <= 1'b0;
            if (done_queue_in) begin
               cnt1 <= nc_done;
               cnt0 <= nc_oth;
            end else begin
               cnt0 <= nc_done;
               cnt1 <= nc_oth;
            end
            if (dropped || nc_done == {(CNT_W+1){1'b0}})
               cur_q <= ~done_queue_in;
         end else if (!busy && mac_ready_in) begin
            // Issue the next descriptor from the chosen non-empty queue.
            if ((cur_q ? ne1 : ne0)) begin
               busy <= 1'b1;
               send_valid_out <= 1'b1;
               send_queue_out <= cur_q;
               send_index_out <= cur_q ? head1 : head0;
               if (cur_q)
                  head1 <= head1 + {{(IDX_W-1){1'b0}}, 1'b1};
               else
                  head0 <= head0 + {{(IDX_W-1){1'b0}}, 1'b1};
            end else if (cur_q ? ne0 : ne1) begin
               cur_q <= ~cur_q;
            end
         end
      end
   end

   // Interrupt cause and write-back pulses; flush forces both.
   always @(posedge clk_in) begin
      if (srst_in) begin
         tx_complete_cause_out <= 1'b0;
         writeback_out <= 1'b0;
         flush_partial_block <= 1'b0;
      end else if (ce_in) begin
         flush_partial_block <= flush_req;
         writeback_out <= flush_req || dly_exp || abs_exp;
         tx_complete_cause_out <= dly_exp || abs_exp || q_imm || flush_req;
      end
   end

   // Read data one cycle after the strobe; flush bit and reserved bits read zero.
   always @(posedge clk_in) begin
      if (srst_in) begin
         rdata_out <= 32'h00000000;
      end else if (ce_in) begin
         rdata_out <= 32'h00000000;
         if (rd_in) begin
            case (addr_in)
               `TQA_OFF_TAIL0: rdata_out <= {16'h0000, tail0};
               `TQA_OFF_TAIL1: rdata_out <= {16'h0000, tail1};
               `TQA_OFF_HEAD0: rdata_out <= {16'h0000, head0};
               `TQA_OFF_HEAD1: rdata_out <= {16'h0000, head1};
               `TQA_OFF_ARB0: rdata_out <= {21'h000000, en0, ratio0, comp0,
                                            cnt0[CNT_W] ? 7'h00 : cnt0[CNT_W-1:0]};
               `TQA_OFF_ARB1: rdata_out <= {21'h000000, en1, ratio1, comp1,
                                            cnt1[CNT_W] ? 7'h00 : cnt1[CNT_W-1:0]};
               `TQA_OFF_DELAY: rdata_out <= {16'h0000, delay_reload_value};
               `TQA_OFF_ABS:   rdata_out <= {16'h0000, abs_reload};
               `TQA_OFF_STATUS: rdata_out <= {28'h0000000, flush_partial_block,
                                              abs_run, dly_run, cur_q};
               default: rdata_out <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/tqa_core_sva.sv
// Concurrent checks on the ports of the transmit queue control.
`timescale 1ns/100ps
`default_nettype none
`include "tqa_consts.vh"
module tqa_core_sva (
   input wire logic                   clk_in,
   input wire logic                   srst_in,
   input wire logic [`TQA_ADDR_W-1:0] addr_in,
   input wire logic [31:0]            wdata_in,
   input wire logic                   wr_in,
   input wire logic                   rd_in,
   input wire logic [31:0]            rdata_out,
   input wire logic                   mac_ready_in,
   input wire logic                   done_in,
   input wire logic                   done_report_status_flag_in,
   input wire logic                   done_delay_enable_flag_in,
   input wire logic                   send_valid_out,
   input wire logic                   writeback_out,
   input wire logic                   tx_complete_cause_out
);
   logic busy;
   // Remembers a descriptor that was issued and has not finished yet.
   always_ff @(posedge clk_in) begin
      if (srst_in)
         busy <= 1'b0;
      else if (send_valid_out)
         busy <= 1'b1;
      else if (done_in)
         busy <= 1'b0;
   end
   issue_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
      busy |-> !send_valid_out) else $error("second issue before completion");
   send_ready_a: assert property (@(posedge clk_in) disable iff (srst_in)
      send_valid_out |-> $past(mac_ready_in)) else $error("issue without ready");
   send_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
      send_valid_out |=> !send_valid_out) else $error("issue longer than a cycle");
   read_quiet_a: assert property (@(posedge clk_in) disable iff (srst_in)
      rdata_out != 32'h0 |-> $past(rd_in)) else $error("read data without read");
   flush_now_a: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_in && addr_in == `TQA_OFF_DELAY && wdata_in[31]
      |=> tx_complete_cause_out && writeback_out) else $error("flush did not fire");
   cause_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
      tx_complete_cause_out |=> !tx_complete_cause_out) else $error("cause not a pulse");
   immed_cause_a: assert property (@(posedge clk_in) disable iff (srst_in)
      done_in && done_report_status_flag_in && !done_delay_enable_flag_in
      |=> tx_complete_cause_out) else $error("immediate cause missing");
   reset_quiet_a: assert property (@(posedge clk_in)
      srst_in |=> !send_valid_out && !tx_complete_cause_out && !writeback_out)
      else $error("output active after reset");
endmodule
bind tqa_core tqa_core_sva u_tqa_core_sva (.clk_in(clk_in), .srst_in(srst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .mac_ready_in(mac_ready_in), .done_in(done_in),
   .done_report_status_flag_in(done_report_status_flag_in),
   .done_delay_enable_flag_in(done_delay_enable_flag_in), .send_valid_out(send_valid_out),
   .writeback_out(writeback_out), .tx_complete_cause_out(tx_complete_cause_out));
`default_nettype wire

// >>> verification/tqa_mac_model.sv
// Behavioural transmitter that takes issued descriptors and reports their completion.
`timescale 1ns/100ps
`default_nettype none
module tqa_mac_model #(
   parameter int LAT = 3
) (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        send_valid_in,
   input  wire logic        send_queue_in,
   input  wire logic [15:0] send_index_in,
   input  wire logic [7:0]  pkts_in,
   input  wire logic [3:0]  rs_mask_in,
   input  wire logic [3:0]  ide_mask_in,
   output var  logic        ready_out = 1'b0,
   output var  logic        done_out = 1'b0,
   output var  logic        done_queue_out = 1'b0,
   output var  logic [7:0]  done_pkts_out = 8'h00,
   output var  logic        done_rs_out = 1'b0,
   output var  logic        done_ide_out = 1'b0
);
   logic [3:0] wait_cnt = 4'h0;
   logic [1:0] idx = 2'h0;
   logic       busy = 1'b0;
   // Finishes one descriptor LAT+1 cycles after it samples the issue; qualifiers toggle while no finish is shown.
   always @(posedge clk_in) begin
      done_out <= 1'b0;
      done_pkts_out <= ~done_pkts_out;
      done_rs_out <= ~done_rs_out;
      done_ide_out <= ~done_ide_out;
      if (srst_in) begin
         busy <= 1'b0;
         ready_out <= 1'b0;
      end else if (send_valid_in) begin
         busy <= 1'b1;
         ready_out <= 1'b0;
         wait_cnt <= 4'(LAT);
         idx <= send_index_in[1:0];
         done_queue_out <= send_queue_in;
      end else if (busy && wait_cnt == 4'h0) begin
         busy <= 1'b0;
         ready_out <= 1'b1;
         done_out <= 1'b1;
         done_pkts_out <= pkts_in;
         done_rs_out <= rs_mask_in[idx];
         done_ide_out <= ide_mask_in[idx];
      end else begin
         wait_cnt <= wait_cnt - 4'h1;
         ready_out <= !busy;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tqa_core_tb.sv
// Self-checking bench for transmit queue registers, arbitration counters and interrupt delay.
`timescale 1ns/100ps
`default_nettype none
`include "tqa_consts.vh"
module tqa_core_tb;
   localparam int TICK = 2;
   logic                   clk_in = 1'b0;
   logic                   srst_in = 1'b1;
   logic [`TQA_ADDR_W-1:0] addr_in = '0;
   logic [31:0]            wdata_in = 32'h0;
   logic [31:0]            rdata_out;
   logic                   wr_in = 1'b0;
   logic                   rd_in = 1'b0;
   logic                   mac_ready_in, done_in, done_queue_in, rs_flag, ide_flag;
   logic [7:0]             done_pkts_in;
   logic [7:0]             pkts = 8'h01;
   logic [3:0]             rs_mask = 4'h3;
   logic [3:0]             ide_mask = 4'h3;
   logic                   send_valid_out, send_queue_out, writeback_out, cause;
   logic [15:0]            send_index_out;
   logic [15:0]            exp_idx = 16'h0;
   int                     err_total = 0, checks = 0, cyc = 0, causes = 0, gap;
   int                     last_done = 0, last_cause = 0, wbs = 0;
   tqa_core #(.TICK_CYC(TICK)) u_tqa_core (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .tx_enable_in(1'b1), .mac_ready_in(mac_ready_in),
      .done_in(done_in), .done_queue_in(done_queue_in), .done_pkts_in(done_pkts_in),
      .done_report_status_flag_in(rs_flag), .done_delay_enable_flag_in(ide_flag),
      .send_valid_out(send_valid_out), .send_queue_out(send_queue_out),
      .send_index_out(send_index_out), .writeback_out(writeback_out),
      .tx_complete_cause_out(cause));
   tqa_mac_model u_tqa_mac_model (.clk_in(clk_in), .srst_in(srst_in),
      .send_valid_in(send_valid_out), .send_queue_in(send_queue_out),
      .send_index_in(send_index_out), .pkts_in(pkts), .rs_mask_in(rs_mask),
      .ide_mask_in(ide_mask), .ready_out(mac_ready_in), .done_out(done_in),
      .done_queue_out(done_queue_in), .done_pkts_out(done_pkts_in), .done_rs_out(rs_flag),
      .done_ide_out(ide_flag));
   // Free-running 40 MHz clock.
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask
   task automatic rst();
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Counts cycles and causes, records finish times, checks issue order, cuts a hang.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (done_in)
         last_done <= cyc;
      if (writeback_out)
         wbs <= wbs + 1;
      if (cause) begin
         causes <= causes + 1;
         last_cause <= cyc;
      end
      if (send_valid_out) begin
         chk({15'h0, send_queue_out, send_index_out}, {16'h0, exp_idx});
         exp_idx <= exp_idx + 16'h1;
      end
      if (srst_in)
         exp_idx <= 16'h0;
      if (cyc > 5000) begin
         err_total++;
         summarize();
      end
   end
   // Main sequence: reset values, flush, delay restart and cancel, reload and compensation.
   initial begin
      rst();
      rd(`TQA_OFF_ARB0, 32'h403);
      rd(`TQA_OFF_ARB1, 32'h403);
      rd(`TQA_OFF_TAIL0, 32'h0);
      rd(18'h03000, 32'h0);
      wr(`TQA_OFF_DELAY, 32'h8000_0004);
      repeat (3) @(posedge clk_in);
      #1 chk(causes, 1);
      chk(wbs, 1);
      rd(`TQA_OFF_DELAY, 32'h4);
      wr(`TQA_OFF_TAIL0, 32'h2);
      repeat (40) @(posedge clk_in);
      #1 gap = last_cause - last_done;
      chk(causes, 2);
      chk(gap >= 4 * TICK && gap <= 5 * TICK + 2, 1);
      rs_mask <= 4'hc;
      ide_mask <= 4'h5;
      // A long delay so that the immediate completion surely comes before expiry.
      wr(`TQA_OFF_DELAY, 32'h10);
      wr(`TQA_OFF_TAIL0, 32'h5);
      repeat (60) @(posedge clk_in);
      #1 chk(causes, 3);
      rst();
      wr(`TQA_OFF_ARB0, 32'h405);
      rd(`TQA_OFF_ARB0, 32'h403);
      wr(`TQA_OFF_TAIL0, 32'h1);
      repeat (20) @(posedge clk_in);
      rd(`TQA_OFF_ARB0, 32'h402);
      wr(`TQA_OFF_TAIL0, 32'h5);
      repeat (60) @(posedge clk_in);
      rd(`TQA_OFF_ARB0, 32'h404);
      pkts <= 8'h08;
      rs_mask <= 4'h0;
      for (int r = 0; r < 4; r++) begin
         rst();
         wr(`TQA_OFF_ARB0, 32'h483);
         wr(`TQA_OFF_ARB1, 32'h483 | (r << 8));
         wr(`TQA_OFF_TAIL0, 32'h1);
         repeat (20) @(posedge clk_in);
         rd(`TQA_OFF_ARB1, 32'h483 + (r << 8) + (5 >> r));
      end
      summarize();
   end
endmodule
`default_nettype wire
